// >>> src/lcd_addr_ctr.sv
/*
  ram address counter: loaded by the address command, advanced per data write.
  assumes: single clock, active low asynchronous reset.
*/
`timescale 1ns/100ps
module lcd_addr_ctr
  import lcd_cmd_pkg::*;
#(
  parameter int AW = RAM_AW
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_nrst,
  input  wire logic          i_ce,
  // control
  input  wire logic          i_load,
  input  wire logic [AW-1:0] i_load_val,
  input  wire logic          i_inc,
  // address
  output logic      [AW-1:0] o_addr
);

  logic [AW-1:0] addr_r;
  logic [AW-1:0] addr_nxt;

  // load beats increment; wraps at top of space
  always_comb begin
    addr_nxt = addr_r;
    if (i_load) begin
      addr_nxt = i_load_val;
    end else if (i_inc) begin
      addr_nxt = addr_r + AW'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_r <= '0;
    end else if (i_ce) begin
      addr_r <= addr_nxt;
    end
  end

  assign o_addr = addr_r;

endmodule : lcd_addr_ctr

// >>> src/lcd_char_ram.sv
/*
  character ram: flip-flop storage with one write port and one read port.
  assumes: written by the interpreter, read by the display side; no clear on reset.
*/
`timescale 1ns/100ps
module lcd_char_ram
  import lcd_cmd_pkg::*;
#(
  parameter int DEPTH = RAM_DEPTH,
  parameter int AW    = RAM_AW
) (
  // clock
  input  wire logic          i_clk,
  input  wire logic          i_ce,
  // write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  // read port
  input  wire logic [AW-1:0] i_raddr,
  output logic      [7:0]    o_rdata
);

  logic [7:0] mem_r [DEPTH];
  logic [7:0] rdata_r;

  // storage: no reset, contents unknown until written
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_cell
      always_ff @(posedge i_clk) begin
        if (i_ce && i_we && (i_waddr == AW'(g))) begin
          mem_r[g] <= i_wdata;
        end
      end
    end
  endgenerate

  // registered read
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      rdata_r <= mem_r[i_raddr];
    end
  end

  assign o_rdata = rdata_r;

endmodule : lcd_char_ram

// >>> src/lcd_cmd_pkg.sv
/*
  constants for the character lcd command interpreter: command codes, field
  positions, reset values and ram layout.
  assumes: used by lcd_command_init_sequence and its two helper modules.
*/
package lcd_cmd_pkg;

  // command byte codes and opcode masks
  localparam logic [7:0] CMD_ADDR_MASK    = 8'h80;
  localparam logic [7:0] CMD_SYSCFG_VAL   = 8'h60;
  localparam logic [7:0] CMD_SYSCFG_MASK  = 8'hF0;
  localparam logic [7:0] CMD_PWRSAVE_VAL  = 8'h40;
  localparam logic [7:0] CMD_PWRSAVE_MASK = 8'hF0;
  localparam logic [7:0] CMD_PWRCTL_VAL   = 8'h50;
  localparam logic [7:0] CMD_PWRCTL_MASK  = 8'hF8;
  localparam logic [7:0] CMD_DISP_VAL     = 8'h30;
  localparam logic [7:0] CMD_DISP_MASK    = 8'hF8;
  localparam logic [7:0] CMD_CONTRAST     = 8'hA8;
  localparam logic [7:0] CMD_ICON_MASK    = 8'hFE;
  localparam logic [7:0] CMD_ICON_VAL     = 8'hA0;

  // field positions inside command bytes
  localparam int DISP_EN_BIT    = 0;
  localparam int DISP_BLINK_BIT = 1;
  localparam int DISP_CURS_BIT  = 2;
  localparam int PWR_REG_BIT    = 0;
  localparam int PWR_FOL_BIT    = 1;
  localparam int PWR_BOOST_BIT  = 2;
  localparam int PS_BIT         = 0;
  localparam int ICON_SEL_BIT   = 0;

  // reset values
  localparam logic [2:0] PWR_RESET      = 3'h0;
  localparam logic [4:0] CONTRAST_RESET = 5'h00;
  localparam logic [7:0] ICON_RESET     = 8'h00;

  // character ram layout
  localparam int          RAM_AW       = 7;
  localparam int          RAM_DEPTH    = 128;
  localparam logic [6:0]  LINE0_BASE   = 7'h30;
  localparam logic [6:0]  LINE1_BASE   = 7'h40;
  localparam logic [6:0]  LINE2_BASE   = 7'h50;
  localparam int          LINE_CHARS   = 13;

  // decoder states
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_CONTRAST = 2'b01,
    ST_ICON     = 2'b11
  } dec_state_e;

endpackage : lcd_cmd_pkg

// >>> src/lcd_command_init_sequence.sv
/*
  command interpreter of a character lcd controller: decodes host command and
  data bytes and holds the display, power, contrast, icon and config state.
  assumes: host write strobe is a one-cycle pulse synchronous to i_clk, and the
  host keeps its own start-up waits.
*/
// Operation
// - reset leaves display, power save, power blocks, icons off, contrast zero.
// - reset does not clear character, glyph or symbol ram contents.
// - lines start at 30h, 40h, 50h, thirteen writes each.
// - command with top bit set, other than A0h/A1h/A8h, loads seven-bit ram address.
// - data byte stores at current address, address then advances.
// - system configuration command 64h selects glyph ram use, lines, scan order.
// - contrast is command A8h followed by data byte carrying value.
// - power command 50h plus three bits switches booster, follower, regulator.
// - display command 30h base with cursor, blink, enable bits.
// - static icons run only in standby; icon command A0h/A1h plus data.
`timescale 1ns/100ps
module lcd_command_init_sequence
  import lcd_cmd_pkg::*;
#(
  parameter int AW = RAM_AW
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_nrst,
  input  wire logic          i_ce,
  // host byte port
  input  wire logic          i_wr,
  input  wire logic          i_register_select,
  input  wire logic [7:0]    i_data,
  // display read port
  input  wire logic [AW-1:0] i_disp_addr,
  output logic      [7:0]    o_disp_char,
  // display control state
  output logic               o_display_on,
  output logic               o_cursor_on,
  output logic               o_blink_on,
  // power control state
  output logic               o_booster_enable,
  output logic               o_follower_enable,
  output logic               o_regulator_enable,
  output logic               o_power_save_bit,
  output logic      [1:0]    o_power_save_opt,
  output logic               o_standby,
  // configuration
  output logic               o_cfg_valid,
  output logic      [3:0]    o_sys_cfg,
  output logic      [4:0]    o_contrast,
  output logic      [7:0]    o_icon0,
  output logic      [7:0]    o_icon1,
  output logic               o_icons_active,
  // status
  output logic      [AW-1:0] o_ram_addr
);

  dec_state_e    state_r,     state_nxt;
  logic [2:0]    disp_r,      disp_nxt;
  logic [2:0]    pwr_r,       pwr_nxt;
  logic [2:0]    ps_r,        ps_nxt;
  logic [3:0]    cfg_r,       cfg_nxt;
  logic          cfg_vld_r,   cfg_vld_nxt;
  logic [4:0]    contrast_r,  contrast_nxt;
  logic [7:0]    icon0_r,     icon0_nxt;
  logic [7:0]    icon1_r,     icon1_nxt;
  logic          icon_sel_r,  icon_sel_nxt;
  logic          is_cmd;
  logic          is_data;
  logic          addr_load;
  logic          ram_we;
  logic [AW-1:0] ram_addr;

  assign is_cmd  = i_wr && !i_register_select;
  assign is_data = i_wr &&  i_register_select;

  // address command: top bit set, low seven bits are the address
  assign addr_load = is_cmd && ((i_data & CMD_ADDR_MASK) == CMD_ADDR_MASK)
                     && (i_data != CMD_CONTRAST)
                     && ((i_data & CMD_ICON_MASK) != CMD_ICON_VAL);

  // data bytes go to ram only when no parameter byte is pending
  assign ram_we = is_data && (state_r == ST_IDLE);

  // address counter
  lcd_addr_ctr #(
    .AW         (AW)
  ) u_addr (
    .i_clk      (i_clk),
    .i_nrst     (i_nrst),
    .i_ce       (i_ce),
    .i_load     (addr_load),
    .i_load_val (i_data[AW-1:0]),
    .i_inc      (ram_we),
    .o_addr     (ram_addr)
  );

  // character ram, line bases 30h/40h/50h fall inside it
  lcd_char_ram #(
    .DEPTH   (RAM_DEPTH),
    .AW      (AW)
  ) u_ram (
    .i_clk   (i_clk),
    .i_ce    (i_ce),
    .i_we    (ram_we),
    .i_waddr (ram_addr),
    .i_wdata (i_data),
    .i_raddr (i_disp_addr),
    .o_rdata (o_disp_char)
  );

  // command decode and parameter byte sequencing
  always_comb begin
    state_nxt    = state_r;
    disp_nxt     = disp_r;
    pwr_nxt      = pwr_r;
    ps_nxt       = ps_r;
    cfg_nxt      = cfg_r;
    cfg_vld_nxt  = cfg_vld_r;
    contrast_nxt = contrast_r;
    icon0_nxt    = icon0_r;
    icon1_nxt    = icon1_r;
    icon_sel_nxt = icon_sel_r;
    // every command is decoded at once; it also drops a pending parameter
    if (is_cmd) begin
      state_nxt = ST_IDLE;
      if (i_data == CMD_CONTRAST) begin
        state_nxt = ST_CONTRAST;
      end else if ((i_data & CMD_ICON_MASK) == CMD_ICON_VAL) begin
        icon_sel_nxt = i_data[ICON_SEL_BIT];
        state_nxt    = ST_ICON;
      end else if ((i_data & CMD_SYSCFG_MASK) == CMD_SYSCFG_VAL) begin
        cfg_nxt     = i_data[3:0];
        cfg_vld_nxt = 1'b1;
      end else if ((i_data & CMD_PWRCTL_MASK) == CMD_PWRCTL_VAL) begin
        pwr_nxt = i_data[2:0];
      end else if ((i_data & CMD_PWRSAVE_MASK) == CMD_PWRSAVE_VAL) begin
        ps_nxt = {i_data[3:2], i_data[PS_BIT]};
      end else if ((i_data & CMD_DISP_MASK) == CMD_DISP_VAL) begin
        disp_nxt = i_data[2:0];
      end
    end else if (is_data) begin
      case (state_r)
        ST_CONTRAST: begin
          contrast_nxt = i_data[4:0];
          state_nxt    = ST_IDLE;
        end
        ST_ICON: begin
          if (icon_sel_r) begin
            icon1_nxt = i_data;
          end else begin
            icon0_nxt = i_data;
          end
          state_nxt = ST_IDLE;
        end
        default: begin
          state_nxt = ST_IDLE; // plain data goes to ram
        end
      endcase
    end
  end

  // state registers; reset values give everything off
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r    <= ST_IDLE;
      disp_r     <= 3'h0;
      pwr_r      <= PWR_RESET;
      ps_r       <= 3'h0;
      cfg_r      <= 4'h0;
      cfg_vld_r  <= 1'b0;
      contrast_r <= CONTRAST_RESET;
      icon0_r    <= ICON_RESET;
      icon1_r    <= ICON_RESET;
      icon_sel_r <= 1'b0;
    end else if (i_ce) begin
      state_r    <= state_nxt;
      disp_r     <= disp_nxt;
      pwr_r      <= pwr_nxt;
      ps_r       <= ps_nxt;
      cfg_r      <= cfg_nxt;
      cfg_vld_r  <= cfg_vld_nxt;
      contrast_r <= contrast_nxt;
      icon0_r    <= icon0_nxt;
      icon1_r    <= icon1_nxt;
      icon_sel_r <= icon_sel_nxt;
    end
  end

  // output mapping
  assign o_display_on       = disp_r[DISP_EN_BIT];
  assign o_cursor_on        = disp_r[DISP_CURS_BIT];
  assign o_blink_on         = disp_r[DISP_BLINK_BIT];
  assign o_booster_enable   = pwr_r[PWR_BOOST_BIT];
  assign o_follower_enable  = pwr_r[PWR_FOL_BIT];
  assign o_regulator_enable = pwr_r[PWR_REG_BIT];
  assign o_power_save_bit   = ps_r[0];
  assign o_power_save_opt   = ps_r[2:1];
  assign o_cfg_valid        = cfg_vld_r;
  assign o_sys_cfg          = cfg_r;
  assign o_contrast         = contrast_r;
  assign o_icon0            = icon0_r;
  assign o_icon1            = icon1_r;
  assign o_ram_addr         = ram_addr;

  // standby: power save set with all power blocks off
  assign o_standby      = ps_r[0] && (pwr_r == 3'h0);
  // icons shown only in standby
  assign o_icons_active = o_standby && !disp_r[DISP_EN_BIT];

endmodule : lcd_command_init_sequence

// >>> verif/lcd_cmd_assertions.sv
/* checker for the lcd command interpreter.
   assumes: bound to the top module; one clock, async low reset. */
`timescale 1ns/100ps
module lcd_cmd_assertions
  import lcd_cmd_pkg::*;
#(parameter int AW = RAM_AW) (
  // host side
  input wire logic          i_clk,
  input wire logic          i_nrst,
  input wire logic          i_ce,
  input wire logic          i_wr,
  input wire logic          i_register_select,
  input wire logic [7:0]    i_data,
  // state outputs
  input wire logic          o_display_on,
  input wire logic          o_cursor_on,
  input wire logic          o_blink_on,
  input wire logic          o_booster_enable,
  input wire logic          o_follower_enable,
  input wire logic          o_regulator_enable,
  input wire logic          o_power_save_bit,
  input wire logic          o_standby,
  input wire logic          o_icons_active,
  input wire logic [4:0]    o_contrast,
  input wire logic [7:0]    o_icon0,
  input wire logic [AW-1:0] o_ram_addr
);
  logic       cmd;
  logic       dat;
  logic       pend_r;
  logic       pend_nxt;
  logic [2:0] pwr;
  // taken bytes and power bits
  assign cmd = i_ce && i_wr && !i_register_select;
  assign dat = i_ce && i_wr && i_register_select;
  assign pwr = {o_booster_enable, o_follower_enable, o_regulator_enable};
  // parameter byte pending after contrast or icon command
  always_comb begin
    pend_nxt = pend_r;
    if (cmd || dat) begin
      pend_nxt = cmd && (i_data inside {CMD_CONTRAST, CMD_ICON_VAL, 8'hA1});
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  chk_reset_clear: assert property (disable iff (1'b0)
    !i_nrst && $past(!i_nrst) |-> !o_display_on && pwr == 3'h0 && !o_power_save_bit
    && o_contrast == 5'h00 && o_ram_addr == '0) else $error("state not cleared by reset");
  chk_addr_load: assert property (
    cmd && i_data[7] && !(i_data inside {8'hA0, 8'hA1, 8'hA8})
    |=> o_ram_addr == $past(i_data[AW-1:0])) else $error("address not loaded");
  chk_addr_step: assert property (
    dat && !pend_r |=> o_ram_addr == $past(o_ram_addr) + 1'b1) else $error("address not stepped");
  chk_power_bits: assert property (
    cmd && i_data[7:3] == 5'h0A |=> pwr == $past(i_data[2:0])) else $error("power bits wrong");
  chk_disp_bits: assert property (
    cmd && i_data[7:3] == 5'h06 |=> {o_cursor_on, o_blink_on, o_display_on} == $past(i_data[2:0]))
    else $error("display bits wrong");
  chk_contrast_pair: assert property (
    cmd && i_data == CMD_CONTRAST ##1 dat |=> o_contrast == $past(i_data[4:0]))
    else $error("contrast not set");
  chk_icon_pair: assert property (
    cmd && i_data == CMD_ICON_VAL ##1 dat |=> o_icon0 == $past(i_data)) else $error("icon not set");
  chk_standby_map: assert property (
    o_standby == (o_power_save_bit && pwr == 3'h0) && o_icons_active == (o_standby && !o_display_on))
    else $error("standby flags wrong");
  chk_idle_hold: assert property (
    !(i_ce && i_wr) |=> $stable({o_display_on, pwr, o_contrast, o_ram_addr}))
    else $error("state moved without a byte");
  // main scenarios reached
  cover property (o_icons_active);
  cover property (cmd && i_data == CMD_CONTRAST ##1 dat);
  cover property (o_display_on && pwr == 3'h7);
endmodule : lcd_cmd_assertions

// >>> verif/lcd_command_init_sequence_tb.sv
/* self-checking bench for the lcd command interpreter.
   assumes: host model drives bytes; effects compared through a queue. */
`timescale 1ns/100ps
module lcd_command_init_sequence_tb;
  import lcd_cmd_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_ce = 1'b1;
  logic        i_wr, i_register_select, wr_d = 1'b0;
  logic [7:0]  i_data, o_disp_char, o_icon0, o_icon1, e_ic0, e_ic1;
  logic [6:0]  i_disp_addr = 7'h00, o_ram_addr, e_addr;
  logic        o_display_on, o_cursor_on, o_blink_on, o_booster_enable;
  logic        o_follower_enable, o_regulator_enable, o_power_save_bit;
  logic        o_standby, o_cfg_valid, o_icons_active, e_ps, e_cv;
  logic [1:0]  o_power_save_opt, e_opt, pend;
  logic [3:0]  o_sys_cfg, e_cfg;
  logic [4:0]  o_contrast, e_con;
  logic [2:0]  e_dsp, e_pwr;
  logic [7:0]  mem [128];
  logic [43:0] obs, q [$];
  logic [31:0] seed = 32'h0000_0008;
  int          n_fail = 0;
  int          n_compared = 0;
  // clock and parts
  always #10 i_clk = ~i_clk;
  lcd_command_init_sequence dut_u (.*);
  lcd_host_model h_u (.i_clk, .o_wr(i_wr), .o_rs(i_register_select), .o_data(i_data));
  assign obs = {o_cursor_on, o_blink_on, o_display_on, o_booster_enable, o_follower_enable,
    o_regulator_enable, o_power_save_bit, o_power_save_opt, o_cfg_valid, o_sys_cfg, o_contrast,
    o_icon0, o_icon1, o_ram_addr, o_standby, o_icons_active};
  // xorshift source
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  // expected state vector
  function automatic logic [43:0] expv();
    logic sb;
    sb = e_ps && e_pwr == 3'h0;
    return {e_dsp, e_pwr, e_ps, e_opt, e_cv, e_cfg, e_con, e_ic0, e_ic1, e_addr, sb, sb && !e_dsp[0]};
  endfunction : expv
  task automatic chk(input logic [43:0] got, input logic [43:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // note expected effect, then send the byte
  task automatic put(input logic r, input logic [7:0] d);
    if (r) begin
      case (pend)
        2'h1: e_con = d[4:0];
        2'h2: e_ic0 = d;
        2'h3: e_ic1 = d;
        default: begin
          mem[e_addr] = d;
          e_addr++;
        end
      endcase
      pend = 2'h0;
    end else begin
      pend = 2'h0;
      if (d == CMD_CONTRAST) pend = 2'h1;
      else if (d[7:1] == 7'h50) pend = {1'b1, d[0]};
      else if (d[7]) e_addr = d[6:0];
      else if (d[7:4] == 4'h6) {e_cv, e_cfg} = {1'b1, d[3:0]};
      else if (d[7:3] == 5'h0A) e_pwr = d[2:0];
      else if (d[7:4] == 4'h4) {e_opt, e_ps} = {d[3:2], d[0]};
      else if (d[7:3] == 5'h06) e_dsp = d[2:0];
    end
    q.push_back(expv());
    h_u.send(r, d);
  endtask : put
  task automatic do_reset();
    i_nrst <= 1'b0;
    {e_dsp, e_pwr, e_ps, e_opt, e_cv, e_cfg, e_con, e_ic0, e_ic1, e_addr, pend} = '0;
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    chk(obs, expv());
  endtask : do_reset
  task automatic rd(input logic [6:0] a);
    @(posedge i_clk);
    i_disp_addr <= a;
    repeat (2) @(posedge i_clk);
    chk({36'h0, o_disp_char}, {36'h0, mem[a]});
  endtask : rd
  // compare each taken byte one cycle later
  always @(posedge i_clk) begin
    wr_d <= i_wr && i_ce && i_nrst;
    if (wr_d) chk(obs, q.pop_front());
  end
  // watchdog
  initial begin
    #400000;
    n_fail++;
    results();
  end
  // main sequence
  initial begin
    do_reset();
    h_u.wait_reset();
    put(0, 8'h64);
    put(0, CMD_CONTRAST);
    put(1, rnd());
    put(0, 8'h4E);
    put(0, 8'h57);
    put(0, CMD_ICON_VAL);
    put(1, 8'h00);
    put(0, 8'hA1);
    put(1, 8'h00);
    for (int l = 0; l < 3; l++) begin
      put(0, {1'b1, LINE0_BASE + 7'(16 * l)});
      repeat (LINE_CHARS) put(1, 8'h20);
    end
    h_u.idle();
    h_u.wait_settle();
    put(0, 8'h31);
    put(0, 8'hB0);
    repeat (5) put(1, rnd());
    // all display and power codes, odd bytes after
    for (int c = 0; c < 8; c++) begin
      put(0, 8'h30 | 8'(c));
      put(0, 8'h50 | 8'(c));
    end
    put(0, 8'h00);
    put(0, CMD_CONTRAST);
    put(0, 8'h31);
    put(1, 8'h41);
    h_u.idle();
    for (int l = 0; l < 3; l++)
      for (int c = 0; c < LINE_CHARS; c++) rd(LINE0_BASE + 7'(16 * l + c));
    // power-off byte while frozen must leave power on
    i_ce <= 1'b0;
    h_u.send(0, 8'h50);
    h_u.idle();
    @(posedge i_clk);
    i_ce <= 1'b1;
    // standby entry and release
    put(0, 8'h30);
    put(0, CMD_ICON_VAL);
    put(1, 8'h10);
    put(0, 8'hA1);
    put(1, 8'h10);
    put(0, 8'h47);
    put(0, 8'h50);
    put(0, 8'h42);
    put(0, 8'h57);
    h_u.idle();
    h_u.wait_settle();
    put(0, 8'h31);
    h_u.idle();
    @(posedge i_clk);
    do_reset();
    rd(7'h35);
    rd(7'h30);
    results();
  end
endmodule : lcd_command_init_sequence_tb
bind lcd_command_init_sequence lcd_cmd_assertions #(.AW(AW)) chk_u (.*);

// >>> verif/lcd_host_model.sv
/* host processor model: drives the byte port and keeps host waits.
   assumes: one clock; bytes launched just after a rising edge. */
`timescale 1ns/100ps
module lcd_host_model #(
  parameter int SETTLE = 100 // shortened power settling wait, cycles
) (
  // clock
  input  wire logic i_clk,
  // byte port
  output logic       o_wr,
  output logic       o_rs,
  output logic [7:0] o_data
);
  // quiet port at start
  initial begin
    o_wr = 1'b0;
    o_rs = 1'b0;
    o_data = 8'h00;
  end
  // one byte per edge, back to back when called again
  task automatic send(input logic rs, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_rs <= rs;
    o_data <= d;
  endtask : send
  // end a burst; released lines show inverted last values
  task automatic idle();
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rs <= ~o_rs;
    o_data <= ~o_data;
  endtask : idle
  // ten microseconds after reset before the first byte
  task automatic wait_reset();
    repeat (500) @(posedge i_clk);
  endtask : wait_reset
  // supply settling before display on, shortened to SETTLE cycles
  task automatic wait_settle();
    repeat (SETTLE) @(posedge i_clk);
  endtask : wait_settle
endmodule : lcd_host_model
